// ---- rtl/homing_pkg.sv ----
// constants, offsets and types for the homing and interrupt sequencer
// assumes one 50 MHz system clock and a 32-bit axi4-lite register port
package homing_pkg;

  // clock and time base
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES_DFLT = MS_NS / CLK_PERIOD_NS;

  // register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_INTP = 8'h00;
  localparam logic [7:0] OFS_SRC = 8'h04;
  localparam logic [7:0] OFS_METHOD = 8'h08;
  localparam logic [7:0] OFS_LIMZ = 8'h0C;
  localparam logic [7:0] OFS_HSPEED = 8'h10;
  localparam logic [7:0] OFS_LSPEED = 8'h14;
  localparam logic [7:0] OFS_RAMP = 8'h18;
  localparam logic [7:0] OFS_TMO = 8'h1C;
  localparam logic [7:0] OFS_ORG_OFF = 8'h20;
  localparam logic [7:0] OFS_MECH_OFF = 8'h24;
  localparam logic [7:0] OFS_CTRL = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2C;
  localparam logic [7:0] OFS_POS = 8'h30;

  // reset values
  localparam logic [15:0] RST_INTP = 16'h0000;
  localparam logic [15:0] RST_SRC = 16'h0000;
  localparam logic [15:0] RST_METHOD = 16'h0002;
  localparam logic [15:0] RST_LIMZ = 16'h0000;
  localparam logic [15:0] RST_HSPEED = 16'h01F4;
  localparam logic [15:0] RST_LSPEED = 16'h0032;
  localparam logic [15:0] RST_RAMP = 16'h03E8;
  localparam logic [15:0] RST_TMO = 16'h7530;
  localparam logic [31:0] RST_OFF = 32'h0000_0000;

  // control and status bit positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_HFAULT = 2;
  localparam int ST_FLIM = 3;
  localparam int ST_RLIM = 4;
  localparam int ST_INTP = 5;

  // synchronised input indices
  localparam int IN_TRIG = 0;
  localparam int IN_ULK = 1;
  localparam int IN_START = 2;
  localparam int IN_HOME = 3;
  localparam int IN_PLIM = 4;
  localparam int IN_NLIM = 5;
  localparam int IN_Z = 6;
  localparam int IN_N = 7;

  // interrupt positioning settings
  localparam logic [15:0] INTP_OFF = 16'h0000;
  localparam logic [15:0] INTP_RISE_AUTO = 16'h0001;
  localparam logic [15:0] INTP_RISE_ULK = 16'h0002;
  localparam logic [15:0] INTP_FALL_AUTO = 16'h0003;
  localparam logic [15:0] INTP_FALL_ULK = 16'h0004;

  // homing start sources
  localparam logic [15:0] SRC_INPUT = 16'h0001;
  localparam logic [15:0] SRC_PANEL = 16'h0002;
  localparam logic [15:0] SRC_COMM = 16'h0003;
  localparam logic [15:0] SRC_SERVO_ON = 16'h0004;

  // homing methods
  localparam logic [15:0] METH_LIM_LAST = 16'h0001;
  localparam logic [15:0] METH_HOME_LAST = 16'h0005;
  localparam logic [15:0] METH_ON_LAST = 16'h0003;
  localparam logic [15:0] METH_Z_LAST = 16'h0007;
  localparam logic [15:0] METH_HERE = 16'h0008;

  // limit and z behaviours
  localparam logic [15:0] LZ_REV = 16'h0000;
  localparam logic [15:0] LZ_FWD = 16'h0001;
  localparam logic [15:0] LZ_ALM_REV = 16'h0003;
  localparam logic [15:0] LZ_ALM_FWD = 16'h0004;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {H_IDLE, H_FAST, H_SLOW, H_SEEKZ} home_state_t;

endpackage

// ---- rtl/homing_positioner.sv ----
// homing sequencer and interrupt positioning for one position axis
// assumes all pins synchronous-capable, one clock, axi4-lite master outside
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/10ps

module homing_positioner
  import homing_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DFLT
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // axi4-lite register port
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // digital inputs and sensors
  input wire logic trig_in,
  input wire logic interrupt_unlock_input,
  input wire logic homing_start_input,
  input wire logic panel_start,
  input wire logic servo_on,
  input wire logic home_sw,
  input wire logic pos_limit,
  input wire logic neg_limit,
  input wire logic z_pulse,
  // motion controller side
  input wire logic intp_move_done,
  input wire logic enc_step,
  input wire logic enc_dir,
  output logic intp_start,
  output logic intp_active,
  output logic homing_busy,
  output logic homing_done,
  output logic motion_en,
  output logic dir_fwd,
  output logic [15:0] speed_cmd,
  output logic [15:0] ramp_ms,
  output logic mech_move_req,
  // alarms and absolute position
  output logic homing_fault_alarm,
  output logic forward_limit_alarm,
  output logic reverse_limit_alarm,
  output logic [31:0] abs_pos
);

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // 16-bit registers sit in the low half; upper byte lanes are dropped
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
    logic [31:0] r;
    r = merge({16'h0000, old}, nw, strb);
    return r[15:0];
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return (a[1:0] == 2'b00) && (a <= OFS_POS);
  endfunction

  // registers
  logic [15:0] intp_set_q, src_q, method_q, limz_q;
  logic [15:0] hs_q, ls_q, ramp_q, tmo_q;
  logic [31:0] org_off_q, mech_off_q;
  logic aw_have_q, w_have_q, wr_fire, comm_start, alarm_clr;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q, rd_val;
  logic [3:0] w_strb_q;

  // write path: address and data taken in either order
  assign awready = !aw_have_q && !bvalid;
  assign wready = !w_have_q && !bvalid;
  assign arready = !rvalid;
  assign wr_fire = aw_have_q && w_have_q && !bvalid;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_have_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_fire)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // control word bits act once per write and are not stored
  assign comm_start = wr_fire && aw_addr_q == OFS_CTRL && w_strb_q[0] &&
                      w_data_q[CTRL_START_BIT];
  assign alarm_clr = wr_fire && aw_addr_q == OFS_CTRL && w_strb_q[0] &&
                     w_data_q[CTRL_CLR_BIT];

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      intp_set_q <= RST_INTP;
      src_q <= RST_SRC;
      method_q <= RST_METHOD;
      limz_q <= RST_LIMZ;
      hs_q <= RST_HSPEED;
      ls_q <= RST_LSPEED;
      ramp_q <= RST_RAMP;
      tmo_q <= RST_TMO;
      org_off_q <= RST_OFF;
      mech_off_q <= RST_OFF;
    end
    else if (wr_fire)
    begin
      unique case (aw_addr_q)
        OFS_INTP: intp_set_q <= merge16(intp_set_q, w_data_q, w_strb_q);
        OFS_SRC: src_q <= merge16(src_q, w_data_q, w_strb_q);
        OFS_METHOD: method_q <= merge16(method_q, w_data_q, w_strb_q);
        OFS_LIMZ: limz_q <= merge16(limz_q, w_data_q, w_strb_q);
        OFS_HSPEED: hs_q <= merge16(hs_q, w_data_q, w_strb_q);
        OFS_LSPEED: ls_q <= merge16(ls_q, w_data_q, w_strb_q);
        OFS_RAMP: ramp_q <= merge16(ramp_q, w_data_q, w_strb_q);
        OFS_TMO: tmo_q <= merge16(tmo_q, w_data_q, w_strb_q);
        OFS_ORG_OFF: org_off_q <= merge(org_off_q, w_data_q, w_strb_q);
        OFS_MECH_OFF: mech_off_q <= merge(mech_off_q, w_data_q, w_strb_q);
        default: ;
      endcase
    end
  end

  // read path, one cycle after address acceptance
  always_comb
  begin
    rd_val = 32'h0000_0000;
    unique case (araddr)
      OFS_INTP: rd_val = {16'h0000, intp_set_q};
      OFS_SRC: rd_val = {16'h0000, src_q};
      OFS_METHOD: rd_val = {16'h0000, method_q};
      OFS_LIMZ: rd_val = {16'h0000, limz_q};
      OFS_HSPEED: rd_val = {16'h0000, hs_q};
      OFS_LSPEED: rd_val = {16'h0000, ls_q};
      OFS_RAMP: rd_val = {16'h0000, ramp_q};
      OFS_TMO: rd_val = {16'h0000, tmo_q};
      OFS_ORG_OFF: rd_val = org_off_q;
      OFS_MECH_OFF: rd_val = mech_off_q;
      OFS_STATUS:
      begin
        rd_val[ST_BUSY] = homing_busy;
        rd_val[ST_DONE] = homing_done;
        rd_val[ST_HFAULT] = homing_fault_alarm;
        rd_val[ST_FLIM] = forward_limit_alarm;
        rd_val[ST_RLIM] = reverse_limit_alarm;
        rd_val[ST_INTP] = intp_active;
      end
      OFS_POS: rd_val = abs_pos;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rdata <= rd_val;
      rresp <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
  end

  // input synchroniser; meta_q feeds only sync_q
  logic [IN_N-1:0] meta_q, sync_q, prev_q, rise, fall;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end
    else
    begin
      meta_q <= {z_pulse, neg_limit, pos_limit, home_sw, homing_start_input,
                 interrupt_unlock_input, trig_in};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;

  // interrupt positioning
  logic trig_ev, intp_rel;
  always_comb
  begin
    trig_ev = 1'b0;
    intp_rel = 1'b0;
    unique case (intp_set_q)
      INTP_RISE_AUTO:
      begin
        trig_ev = rise[IN_TRIG];
        intp_rel = intp_move_done;
      end
      INTP_RISE_ULK:
      begin
        trig_ev = rise[IN_TRIG];
        intp_rel = rise[IN_ULK];
      end
      INTP_FALL_AUTO:
      begin
        trig_ev = fall[IN_TRIG];
        intp_rel = intp_move_done;
      end
      INTP_FALL_ULK:
      begin
        trig_ev = fall[IN_TRIG];
        intp_rel = rise[IN_ULK];
      end
      default: ;
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      intp_active <= 1'b0;
      intp_start <= 1'b0;
    end
    else
    begin
      intp_start <= trig_ev && !intp_active;
      if (intp_set_q == INTP_OFF)
        intp_active <= 1'b0;
      else if (trig_ev && !intp_active)
        intp_active <= 1'b1;
      else if (intp_rel)
        intp_active <= 1'b0;
    end
  end

  // homing start selection
  logic servo_prev_q, first_on_q, start_req;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      servo_prev_q <= 1'b0;
      first_on_q <= 1'b0;
    end
    else
    begin
      servo_prev_q <= servo_on;
      if (servo_on)
        first_on_q <= 1'b1;
    end
  end

  always_comb
  begin
    unique case (src_q)
      SRC_INPUT: start_req = rise[IN_START];
      SRC_PANEL: start_req = panel_start;
      SRC_COMM: start_req = comm_start;
      SRC_SERVO_ON: start_req = servo_on && !servo_prev_q && !first_on_q;
      default: start_req = 1'b0;
    endcase
  end

  // millisecond time base, runs only while homing
  home_state_t state_q, state_d;
  logic [31:0] tick_q;
  logic [15:0] ms_q;
  logic timeout;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      tick_q <= 32'h0000_0000;
      ms_q <= 16'h0000;
    end
    else if (state_q == H_IDLE)
    begin
      tick_q <= 32'h0000_0000;
      ms_q <= 16'h0000;
    end
    else if (tick_q == 32'(MS_CYCLES - 1))
    begin
      tick_q <= 32'h0000_0000;
      ms_q <= ms_q + 16'h0001;
    end
    else
      tick_q <= tick_q + 32'h0000_0001;
  end
  assign timeout = state_q != H_IDLE && ms_q >= tmo_q;

  // homing sequencer
  logic dir_q, dir_d, origin_hit, fault_set, lim_now, lim_m, home_m;
  logic at_origin;
  assign lim_now = dir_q ? sync_q[IN_PLIM] : sync_q[IN_NLIM];
  assign lim_m = method_q <= METH_LIM_LAST;
  assign home_m = !lim_m && method_q <= METH_HOME_LAST;

  always_comb
  begin
    state_d = state_q;
    dir_d = dir_q;
    origin_hit = 1'b0;
    fault_set = 1'b0;
    at_origin = 1'b0;
    unique case (state_q)
      H_IDLE:
      begin
        if (start_req && method_q == METH_HERE)
          origin_hit = 1'b1;
        else if (start_req && method_q <= METH_Z_LAST)
        begin
          state_d = H_FAST;
          dir_d = ~method_q[0];
        end
      end
      H_SEEKZ:
      begin
        if (timeout)
        begin
          fault_set = 1'b1;
          state_d = H_IDLE;
        end
        else if (rise[IN_Z])
        begin
          origin_hit = 1'b1;
          state_d = H_IDLE;
        end
      end
      default:
      begin
        if (timeout)
        begin
          fault_set = 1'b1;
          state_d = H_IDLE;
        end
        else if (lim_now && lim_m)
        begin
          // limit reached: it is the origin or the start of a z search
          if (limz_q == LZ_REV || limz_q == LZ_ALM_REV)
          begin
            state_d = H_SEEKZ;
            dir_d = ~dir_q;
          end
          else if (limz_q == LZ_FWD || limz_q == LZ_ALM_FWD)
          begin
            state_d = H_SEEKZ;
            dir_d = 1'b1;
          end
          else
          begin
            origin_hit = 1'b1;
            state_d = H_IDLE;
          end
        end
        else if (lim_now && home_m && limz_q >= LZ_ALM_REV)
        begin
          fault_set = 1'b1;
          state_d = H_IDLE;
        end
        else if (lim_now)
          dir_d = ~dir_q;
        else if (home_m && method_q <= METH_ON_LAST)
          at_origin = rise[IN_HOME];
        else if (home_m && state_q == H_FAST && rise[IN_HOME])
          state_d = H_SLOW;
        else if (home_m)
          at_origin = fall[IN_HOME];
        else if (rise[IN_Z])
        begin
          origin_hit = 1'b1;
          state_d = H_IDLE;
        end
        if (at_origin)
        begin
          if (limz_q == LZ_ALM_REV)
          begin
            state_d = H_SEEKZ;
            dir_d = ~dir_q;
          end
          else if (limz_q == LZ_ALM_FWD)
          begin
            state_d = H_SEEKZ;
            dir_d = 1'b1;
          end
          else
          begin
            origin_hit = 1'b1;
            state_d = H_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= H_IDLE;
      dir_q <= 1'b1;
      speed_cmd <= 16'h0000;
      motion_en <= 1'b0;
      mech_move_req <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      dir_q <= dir_d;
      motion_en <= state_d != H_IDLE;
      mech_move_req <= origin_hit && mech_off_q != 32'h0000_0000;
      unique case (state_d)
        H_FAST: speed_cmd <= hs_q;
        H_SLOW, H_SEEKZ: speed_cmd <= ls_q;
        default: speed_cmd <= 16'h0000;
      endcase
    end
  end
  assign homing_busy = state_q != H_IDLE;
  assign dir_fwd = dir_q;
  assign ramp_ms = ramp_q;

  // sticky flags: a set in the clearing cycle wins
  logic lim8, flim_set, rlim_set;
  assign lim8 = method_q == METH_HERE && limz_q >= LZ_ALM_REV;
  assign flim_set = lim8 && rise[IN_PLIM];
  assign rlim_set = lim8 && rise[IN_NLIM];
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      homing_fault_alarm <= 1'b0;
      forward_limit_alarm <= 1'b0;
      reverse_limit_alarm <= 1'b0;
      homing_done <= 1'b0;
    end
    else
    begin
      homing_fault_alarm <= fault_set || (homing_fault_alarm && !alarm_clr);
      forward_limit_alarm <= flim_set || (forward_limit_alarm && !alarm_clr);
      reverse_limit_alarm <= rlim_set || (reverse_limit_alarm && !alarm_clr);
      if (origin_hit)
        homing_done <= 1'b1;
      else if (state_d != H_IDLE)
        homing_done <= 1'b0;
    end
  end

  // absolute position counter
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      abs_pos <= 32'h0000_0000;
    else if (origin_hit)
      abs_pos <= org_off_q;
    else if (enc_step)
      abs_pos <= enc_dir ? abs_pos + 32'h0000_0001 : abs_pos - 32'h0000_0001;
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  property p_intp_off;
    intp_set_q == INTP_OFF |=> !intp_active && !intp_start;
  endproperty
  a_intp_off: assert property (p_intp_off)
    else $error("interrupt positioning active while disabled");

  property p_rise_start;
    intp_set_q == INTP_RISE_AUTO && rise[IN_TRIG] && !intp_active
      |=> intp_start && intp_active ##1 !intp_start;
  endproperty
  a_rise_start: assert property (p_rise_start)
    else $error("rising trigger did not start one interrupt move");

  property p_ulk_hold;
    intp_set_q == INTP_RISE_ULK && intp_active && !rise[IN_ULK]
      && $stable(intp_set_q) |=> intp_active;
  endproperty
  a_ulk_hold: assert property (p_ulk_hold)
    else $error("interrupt released without unlock");

  property p_fall_start;
    intp_set_q == INTP_FALL_AUTO && fall[IN_TRIG] && !intp_active
      |=> intp_active;
  endproperty
  a_fall_start: assert property (p_fall_start)
    else $error("falling trigger did not start interrupt move");

  property p_auto_rel;
    intp_set_q == INTP_FALL_AUTO && intp_active && intp_move_done
      && !fall[IN_TRIG] |=> !intp_active;
  endproperty
  a_auto_rel: assert property (p_auto_rel)
    else $error("interrupt state not released after move");

  property p_here;
    state_q == H_IDLE && start_req && method_q == METH_HERE
      && org_off_q == RST_OFF |=> homing_done && abs_pos == 32'h0000_0000
      && !motion_en;
  endproperty
  a_here: assert property (p_here)
    else $error("method 8 did not take present position");

  property p_timeout;
    state_q != H_IDLE && ms_q >= tmo_q
      |=> homing_fault_alarm && state_q == H_IDLE ##1 speed_cmd == 16'h0000;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("homing time limit did not raise the alarm");

  property p_fast_speed;
    state_q == H_FAST && $stable(hs_q) && $past(state_d) == H_FAST
      |-> speed_cmd == hs_q && motion_en;
  endproperty
  a_fast_speed: assert property (p_fast_speed)
    else $error("search not at the high speed");

  property p_origin_load;
    origin_hit |=> abs_pos == $past(org_off_q) && homing_done;
  endproperty
  a_origin_load: assert property (p_origin_load)
    else $error("position counter not loaded at origin");

  property p_lim_alarm;
    state_q == H_FAST && home_m && lim_now && limz_q >= LZ_ALM_REV
      && !timeout |=> homing_fault_alarm && state_q == H_IDLE;
  endproperty
  a_lim_alarm: assert property (p_lim_alarm)
    else $error("limit in home switch search did not stop with alarm");

endmodule

// ---- dv/axis_model.sv ----
// switch and z pulse model of the axis under homing
// assumes motion_en from the design; hide keeps the switch unseen
`timescale 1ns/10ps
module axis_model #(
  parameter int HOME_AT = 12
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // motion command and test control
  input wire logic motion_en,
  input wire logic hide,
  // sensors
  output logic home_sw,
  output logic z_pulse
);
  int cnt_q;
  // travel counts only while moving, so the switch drops once stopped
  always_ff @(posedge mclk or posedge rst)
    if (rst)
      cnt_q <= 0;
    else if (!motion_en || hide)
      cnt_q <= 0;
    else
      cnt_q <= cnt_q + 1;
  assign home_sw = cnt_q >= HOME_AT;
  assign z_pulse = motion_en && cnt_q[2:0] == 3'h7;
endmodule

// ---- dv/tb_top.sv ----
// bench for the homing sequencer: axi4-lite tasks and pin stimulus
// assumes the sensor model and a 10-cycle millisecond
`timescale 1ns/10ps
module tb_top;
  import homing_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, abs_pos, q;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic bready = 1'b1, rready = 1'b1;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic trig = 1'b0, ulk = 1'b0, hstart = 1'b0, servo = 1'b0;
  logic done_in = 1'b0, step = 1'b0, hide = 1'b0;
  logic home_sw, z_pulse, intp_active, motion_en, dir_fwd;
  logic homing_done, hfault;
  logic plim = 1'b0, nlim = 1'b0, flim, rlim;
  logic [15:0] speed_cmd;
  logic [7:0] ra [6] = '{OFS_INTP, OFS_METHOD, OFS_HSPEED, OFS_LSPEED,
    OFS_RAMP, OFS_TMO};
  logic [31:0] rv [6] = '{32'h0, 32'h2, 32'h1F4, 32'h32, 32'h3E8, 32'h7530};
  int fails = 0;
  int tests_run = 0;
  always #10 mclk = ~mclk;
  homing_positioner #(.MS_CYCLES(10)) u_dut (.mclk, .rst, .awaddr,
    .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .trig_in(trig),
    .interrupt_unlock_input(ulk), .homing_start_input(hstart),
    .panel_start(1'b0), .servo_on(servo), .home_sw, .pos_limit(plim),
    .neg_limit(nlim), .z_pulse, .intp_move_done(done_in), .enc_step(step),
    .enc_dir(step), .intp_start(), .intp_active, .homing_busy(),
    .homing_done, .motion_en, .dir_fwd, .speed_cmd, .ramp_ms(),
    .mech_move_req(), .homing_fault_alarm(hfault),
    .forward_limit_alarm(flim), .reverse_limit_alarm(rlim), .abs_pos);
  axis_model u_axis (.mclk, .rst, .motion_en, .hide, .home_sw, .z_pulse);
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic close_out;
    if (fails == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang(input int n);
    if (n > 200)
    begin
      fails++;
      close_out();
    end
  endtask
  // ready is looked at mid-cycle, where it is settled for the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ta, tw, tb;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    n = 0;
    do
    begin
      @(negedge mclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      @(posedge mclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      n++;
      hang(n);
    end
    while (!tb);
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    logic ta, tr;
    araddr <= a;
    arvalid <= 1'b1;
    n = 0;
    do
    begin
      @(negedge mclk);
      ta = arvalid & arready;
      tr = rvalid;
      q = rdata;
      rsp = rresp;
      @(posedge mclk);
      if (ta) arvalid <= 1'b0;
      n++;
      hang(n);
    end
    while (!tr);
  endtask
  task automatic until_hi(input bit f);
    int n;
    for (n = 0; (f ? hfault : homing_done) !== 1'b1; n++)
    begin
      cyc(1);
      hang(n);
    end
  endtask
  initial
  begin
    cyc(2);
    rst <= 1'b0;
    cyc(1);
    foreach (ra[i])
    begin
      rd(ra[i]);
      chk(q, rv[i]);
    end
    rd(8'h3C);
    chk({q[31:2], rsp}, 32'h2);
    trig <= 1'b1;
    cyc(6);
    chk(intp_active, 32'h0);
    for (int s = 1; s < 5; s++)
    begin
      wr(OFS_INTP, s);
      trig <= s > 2;
      cyc(6);
      chk(intp_active, 32'h0);
      trig <= s < 3;
      cyc(6);
      chk(intp_active, 32'h1);
      done_in <= 1'b1;
      cyc(1);
      done_in <= 1'b0;
      cyc(3);
      chk(intp_active, !s[0]);
      ulk <= 1'b1;
      cyc(6);
      chk(intp_active, 32'h0);
      ulk <= 1'b0;
    end
    wr(OFS_SRC, 32'h3);
    wr(OFS_ORG_OFF, 32'h1234);
    wr(OFS_CTRL, 32'h1);
    cyc(1);
    chk({dir_fwd, motion_en, speed_cmd}, 32'h301F4);
    until_hi(1'b0);
    chk(abs_pos, 32'h1234);
    chk({motion_en, speed_cmd}, 32'h0);
    wr(OFS_METHOD, 32'h8);
    wr(OFS_ORG_OFF, 32'h55);
    wr(OFS_CTRL, 32'h1);
    cyc(4);
    chk({homing_done, motion_en, abs_pos[15:0]}, 32'h20055);
    wr(OFS_METHOD, 32'h2);
    wr(OFS_TMO, 32'h2);
    hide <= 1'b1;
    wr(OFS_CTRL, 32'h1);
    cyc(12);
    chk(hfault, 32'h0);
    until_hi(1'b1);
    chk({hfault, motion_en, homing_done}, 32'h4);
    wr(OFS_CTRL, 32'h2);
    wr(OFS_METHOD, 32'h8);
    wr(OFS_LIMZ, 32'h3);
    plim <= 1'b1;
    nlim <= 1'b1;
    cyc(5);
    chk({hfault, flim, rlim}, 32'h3);
    plim <= 1'b0;
    nlim <= 1'b0;
    wr(OFS_METHOD, 32'h2);
    wr(OFS_CTRL, 32'h3);
    chk({hfault, flim, motion_en}, 32'h1);
    plim <= 1'b1;
    cyc(5);
    chk({hfault, motion_en}, 32'h2);
    plim <= 1'b0;
    wr(OFS_SRC, 32'h1);
    hstart <= 1'b1;
    cyc(5);
    chk(motion_en, 32'h1);
    cyc(30);
    chk(motion_en, 32'h0);
    wr(OFS_SRC, 32'h4);
    servo <= 1'b1;
    cyc(2);
    chk({motion_en, speed_cmd}, 32'h101F4);
    close_out();
  end
endmodule
